// ==== rtl/gam_consts.svh ====
// Offsets, reset values, field positions and mode codes of the
// address mode configuration block. Included by the configuration module only.
`ifndef GAM_CONSTS_SVH
`define GAM_CONSTS_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define GAM_OFF_MODE 8'h08
`define GAM_OFF_PRIM 8'h0C
`define GAM_OFF_SEC 8'h10
`define GAM_OFF_MATCH 8'h14
// ----------------------------------------
// Reset values
// ----------------------------------------
`define GAM_MODE_RST 8'h30
`define GAM_PRIM_RST 8'h00
`define GAM_SEC_RST 8'h80
// ----------------------------------------
// Field positions
// ----------------------------------------
`define GAM_BIT_TDIS 6
`define GAM_BIT_LDIS 5
// ----------------------------------------
// Mode selector codes
// ----------------------------------------
`define GAM_CODE_NONE 8'h30
`define GAM_CODE_NORMAL 8'h31
`define GAM_CODE_EXT 8'h32
`define GAM_CODE_EXT_DUAL 8'h33
`define GAM_CODE_TALK_ONLY 8'hB0
`define GAM_CODE_LISTEN_ONLY 8'h70
`define GAM_CODE_TALK_LISTEN 8'hF0
// ----------------------------------------
// Bus answers
// ----------------------------------------
`define GAM_RESP_OKAY 2'b00
`define GAM_RESP_SLVERR 2'b10
`endif

// ==== rtl/gam_pkg.sv ====
// Types shared by the address mode configuration block.
// Assumes the constants header is on the include path.
package gam_pkg;
	typedef enum logic [2:0] {
		GAM_NONE,
		GAM_NORMAL,
		GAM_EXT,
		GAM_EXT_DUAL,
		GAM_TALK_ONLY,
		GAM_LISTEN_ONLY,
		GAM_TALK_LISTEN
	} gam_mode_t;
endpackage

// ==== rtl/gam_addr_cmp.sv ====
// One address comparator: five-bit station id against a command byte.
// Assumes the command byte is stable while its strobe is high.
`timescale 1ns/100ps
module gam_addr_cmp #(
	parameter int AW = 5
) (
	// Settings
	input wire logic allow,
	input wire logic disable_bit,
	input wire logic [AW-1:0] station_id,
	// Command
	input wire logic [7:0] cmd_byte,
	// Result
	output logic hit
);
	assign hit = allow && !disable_bit &&
		(cmd_byte[AW-1:0] == station_id); // R7 R8 R11
endmodule // gam_addr_cmp

// ==== rtl/gam_cfg.sv ====
// Address mode configuration: AXI4-Lite registers and address matching.
// Assumes talk/listen command strobes synchronous to aclk.
//
// Summary of operation
// R1: Write-only eight-bit mode selector at 0x08, reset 0x30 (no addressing).
// R2: Software should set the mode before clearing the power-on hold.
// R3: 0x31 normal/normal dual, 0x32 extended, 0x33 extended dual.
// R4: 0x30 covers none and multiple addressing; no address recognition.
// R5: 0xB0 talk only, 0x70 listen only, 0xF0 talk and listen.
// R6: Write-only primary register at 0x0C: talk disable, listen disable, id.
// R7: Talker disable set stops primary talk address comparison.
// R8: Listener disable set stops primary listen address comparison.
// R9: Primary id used in normal, extended and dual modes only.
// R10: Second id is secondary address, or device two in normal dual; the code also matches it as device two in extended dual (0x33).
// R11: Compare low five bits of received command when mode allows.
// R12: Reset loads all three registers with reset values together.
`timescale 1ns/100ps
`include "gam_consts.svh"
module gam_cfg
	import gam_pkg::*;
#(
	parameter int AW = 5
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Received GPIB commands
	input wire logic [7:0] cmd_byte,
	input wire logic talk_cmd_stb,
	input wire logic listen_cmd_stb,
	// Settings to the bus engines
	output logic [2:0] mode_code,
	output logic talk_only,
	output logic listen_only,
	// Address match pulses
	output logic primary_talk_hit,
	output logic primary_listen_hit,
	output logic second_talk_hit,
	output logic second_listen_hit
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] mode_selector_reg, primary_station_reg;
	logic [7:0] secondary_station_reg, aw_addr;
	logic [3:0] match_seen;
	logic [31:0] w_data;
	logic dual_sel, aw_held, w_held, w_lane0, wr_fire;
	gam_mode_t mode, next_mode;
	logic prim_allow, sec_allow;
	logic [AW-1:0] first_station_id, second_station_id;
	logic pt_hit, pl_hit, st_hit, sl_hit;

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	// Code 0x31 serves normal and normal dual alike; dual_sel splits them
	always_comb begin
		unique case (mode_selector_reg)
			`GAM_CODE_NORMAL: next_mode = GAM_NORMAL; // R3
			`GAM_CODE_EXT: next_mode = GAM_EXT; // R3
			`GAM_CODE_EXT_DUAL: next_mode = GAM_EXT_DUAL; // R3
			`GAM_CODE_TALK_ONLY: next_mode = GAM_TALK_ONLY; // R5
			`GAM_CODE_LISTEN_ONLY: next_mode = GAM_LISTEN_ONLY; // R5
			`GAM_CODE_TALK_LISTEN: next_mode = GAM_TALK_LISTEN; // R5
			default: next_mode = GAM_NONE; // R4
		endcase
	end
	assign mode = next_mode;
	assign prim_allow = (mode == GAM_NORMAL) || (mode == GAM_EXT) ||
		(mode == GAM_EXT_DUAL); // R9
	// Extended mode: second id is a secondary address, not matched here
	assign sec_allow = ((mode == GAM_NORMAL) && dual_sel) ||
		(mode == GAM_EXT_DUAL); // R10
	assign first_station_id = primary_station_reg[AW-1:0]; // R9
	assign second_station_id = secondary_station_reg[AW-1:0]; // R10

	// ----------------------------------------
	// Comparators
	// ----------------------------------------
	gam_addr_cmp #(.AW(AW)) u_pt (.allow(prim_allow && talk_cmd_stb),
		.disable_bit(primary_station_reg[`GAM_BIT_TDIS]),
		.station_id(first_station_id), .cmd_byte(cmd_byte),
		.hit(pt_hit)); // R7
	gam_addr_cmp #(.AW(AW)) u_pl (.allow(prim_allow && listen_cmd_stb),
		.disable_bit(primary_station_reg[`GAM_BIT_LDIS]),
		.station_id(first_station_id), .cmd_byte(cmd_byte),
		.hit(pl_hit)); // R8
	gam_addr_cmp #(.AW(AW)) u_st (.allow(sec_allow && talk_cmd_stb),
		.disable_bit(secondary_station_reg[`GAM_BIT_TDIS]),
		.station_id(second_station_id), .cmd_byte(cmd_byte),
		.hit(st_hit)); // R10
	gam_addr_cmp #(.AW(AW)) u_sl (.allow(sec_allow && listen_cmd_stb),
		.disable_bit(secondary_station_reg[`GAM_BIT_LDIS]),
		.station_id(second_station_id), .cmd_byte(cmd_byte),
		.hit(sl_hit)); // R10

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			primary_talk_hit <= 1'b0;
			primary_listen_hit <= 1'b0;
			second_talk_hit <= 1'b0;
			second_listen_hit <= 1'b0;
			mode_code <= 3'd0;
			talk_only <= 1'b0;
			listen_only <= 1'b0;
		end else begin
			primary_talk_hit <= pt_hit; // R11
			primary_listen_hit <= pl_hit; // R11
			second_talk_hit <= st_hit;
			second_listen_hit <= sl_hit;
			mode_code <= mode;
			talk_only <= (mode == GAM_TALK_ONLY) ||
				(mode == GAM_TALK_LISTEN); // R5
			listen_only <= (mode == GAM_LISTEN_ONLY) ||
				(mode == GAM_TALK_LISTEN); // R5
		end
	end

	// ----------------------------------------
	// AXI4-Lite write path
	// ----------------------------------------
	// Address and data are latched in either order; response follows both
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_lane0 <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_lane0 <= s_axi_wstrb[0];
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_selector_reg <= `GAM_MODE_RST; // R1 R12
			primary_station_reg <= `GAM_PRIM_RST; // R6 R12
			secondary_station_reg <= `GAM_SEC_RST; // R12
			dual_sel <= 1'b0;
		end else if (wr_fire && w_lane0) begin
			unique case (aw_addr)
				`GAM_OFF_MODE: mode_selector_reg <= w_data[7:0]; // R1
				// Bit 7 is held at zero whatever is written
				`GAM_OFF_PRIM: primary_station_reg <= {1'b0, w_data[6:0]}; // R6
				`GAM_OFF_SEC: begin
					secondary_station_reg <= w_data[7:0];
					dual_sel <= w_data[8];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `GAM_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (aw_addr == `GAM_OFF_MODE ||
				aw_addr == `GAM_OFF_PRIM || aw_addr == `GAM_OFF_SEC) ?
				`GAM_RESP_OKAY : `GAM_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// AXI4-Lite read path
	// ----------------------------------------
	// Write-only registers read as zero; only the match flags and decoded mode are visible
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			match_seen <= 4'h0;
		end else begin
			// A new hit wins over the clearing read in the same cycle
			match_seen <= ((s_axi_arvalid && s_axi_arready &&
				s_axi_araddr == `GAM_OFF_MATCH) ? 4'h0 : match_seen) |
				{sl_hit, st_hit, pl_hit, pt_hit};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `GAM_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			unique case (s_axi_araddr)
				`GAM_OFF_MATCH: begin
					s_axi_rdata <= {25'h0, mode, match_seen};
					s_axi_rresp <= `GAM_RESP_OKAY;
				end
				`GAM_OFF_MODE, `GAM_OFF_PRIM, `GAM_OFF_SEC: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `GAM_RESP_OKAY;
				end
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `GAM_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_reset_mode: assert property (@(posedge aclk)
		!aresetn |=> mode_selector_reg == `GAM_MODE_RST &&
		primary_station_reg == `GAM_PRIM_RST) // R1
		else $error("mode or primary not at reset value");
	a_prim_bit7: assert property (@(posedge aclk) disable iff (!aresetn)
		primary_station_reg[7] == 1'b0) // R6
		else $error("primary bit 7 set");
	a_talk_dis: assert property (@(posedge aclk) disable iff (!aresetn)
		primary_station_reg[`GAM_BIT_TDIS] && $stable(primary_station_reg)
		|=> !primary_talk_hit) // R7
		else $error("talk hit while talker disabled");
	a_listen_dis: assert property (@(posedge aclk) disable iff (!aresetn)
		primary_station_reg[`GAM_BIT_LDIS] && $stable(primary_station_reg)
		|=> !primary_listen_hit) // R8
		else $error("listen hit while listener disabled");
	a_talk_match: assert property (@(posedge aclk) disable iff (!aresetn)
		talk_cmd_stb && prim_allow && !primary_station_reg[`GAM_BIT_TDIS] &&
		cmd_byte[4:0] == primary_station_reg[4:0] |=> primary_talk_hit) // R11
		else $error("talk match missed");
	a_none_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
		mode_selector_reg == `GAM_CODE_NONE ##1
		mode_selector_reg == `GAM_CODE_NONE |-> !primary_talk_hit &&
		!primary_listen_hit && !second_talk_hit && !second_listen_hit) // R4
		else $error("hit in no-address mode");
	a_only_modes: assert property (@(posedge aclk) disable iff (!aresetn)
		mode_selector_reg == `GAM_CODE_TALK_LISTEN |=> talk_only &&
		listen_only) // R5
		else $error("talk and listen mode not shown");
	a_prim_unused: assert property (@(posedge aclk) disable iff (!aresetn)
		!prim_allow |=> !primary_talk_hit && !primary_listen_hit) // R9
		else $error("primary used in wrong mode");
	a_ext_code: assert property (@(posedge aclk) disable iff (!aresetn)
		mode_selector_reg == `GAM_CODE_EXT |-> mode == GAM_EXT) // R3
		else $error("extended code misdecoded");
	a_sec_ext: assert property (@(posedge aclk) disable iff (!aresetn)
		mode == GAM_EXT |=> !second_talk_hit && !second_listen_hit) // R10
		else $error("second id matched in extended mode");
	c_write_mode: cover property (@(posedge aclk)
		wr_fire && aw_addr == `GAM_OFF_MODE);
	c_talk_hit: cover property (@(posedge aclk) primary_talk_hit);
	c_dual_hit: cover property (@(posedge aclk) second_listen_hit);
	c_read_match: cover property (@(posedge aclk)
		s_axi_rvalid && s_axi_rready);
endmodule // gam_cfg

// ==== verification/gam_ctl_model.sv ====
// Model of the bus controller that sends talk and listen commands.
// Assumes the bench calls send from its main process only.
`timescale 1ns/100ps
module gam_ctl_model (
	// Clock
	input wire logic aclk,
	// Command link
	output logic [7:0] cmd_byte,
	output logic talk_cmd_stb,
	output logic listen_cmd_stb
);
	initial begin
		cmd_byte = 8'h00;
		talk_cmd_stb = 1'b0;
		listen_cmd_stb = 1'b0;
	end
	// Talk group 010x_xxxx, listen group 001x_xxxx; outside a strobe the
	// byte is inverted so a design that ignores the strobe sees garbage
	task automatic send(input logic talk, input logic [4:0] id);
		@(posedge aclk);
		cmd_byte <= {1'b0, talk, !talk, id};
		talk_cmd_stb <= talk;
		listen_cmd_stb <= !talk;
		@(posedge aclk);
		cmd_byte <= ~cmd_byte;
		talk_cmd_stb <= 1'b0;
		listen_cmd_stb <= 1'b0;
	endtask
endmodule // gam_ctl_model

// ==== verification/tb_top.sv ====
// Self-checking bench for the address mode configuration block.
// Assumes a 20 MHz clock and the controller model beside the design.
`timescale 1ns/100ps
module tb_top;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic talk_only, listen_only, tstb, lstb;
	logic [7:0] awaddr, araddr, cmd_byte;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, hits;
	logic [1:0] bresp, rresp;
	logic [2:0] mode_code;
	int miscompares, n_tests;

	gam_cfg dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.cmd_byte(cmd_byte), .talk_cmd_stb(tstb), .listen_cmd_stb(lstb),
		.mode_code(mode_code), .talk_only(talk_only),
		.listen_only(listen_only), .primary_talk_hit(hits[3]),
		.primary_listen_hit(hits[2]), .second_talk_hit(hits[1]),
		.second_listen_hit(hits[0]));
	gam_ctl_model u_ctl (.aclk(aclk), .cmd_byte(cmd_byte),
		.talk_cmd_stb(tstb), .listen_cmd_stb(lstb));

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask
	// Handshakes are judged 1 ns after an edge, as the next edge will sample them
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic aw, w, b;
		logic [1:0] r;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		b = 1'b0;
		// Only the watchdog ends a wait for the answer
		while (!b) begin
			#1;
			aw = awvalid && awready;
			w = wvalid && wready;
			b = bvalid && bready;
			r = bresp;
			@(posedge aclk);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		chk(32'(r), 32'(er));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		logic ar, done;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		done = 1'b0;
		while (!done) begin
			#1;
			ar = arvalid && arready;
			done = rvalid && rready;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ar) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		chk(d, ed);
		chk(32'(r), 32'(er));
	endtask
	// Hit order {primary talk, primary listen, second talk, second listen}
	task automatic hit(input logic t, input logic [4:0] id,
		input logic [3:0] e);
		u_ctl.send(t, id);
		#1 chk(32'(hits), 32'(e));
		@(posedge aclk);
		#1 chk(32'(hits), 32'h0000_0000);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		chk(32'({mode_code, talk_only, listen_only}), 32'h0000_0000);
		rd(8'h08, 32'h0000_0000, 2'b00);
		hit(1'b1, 5'h00, 4'h0);
		wr(8'h08, 32'h0000_0031, 2'b00);
		hit(1'b1, 5'h00, 4'h8);
		rd(8'h14, 32'h0000_0011, 2'b00);
		$display("t_reset done");
	endtask
	task automatic t_modes;
		logic [7:0] c[8] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'hB0, 8'h70,
			8'hF0, 8'h34};
		logic [4:0] e[8] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h12, 5'h15,
			5'h1B, 5'h00};
		for (int i = 0; i < 8; i++) begin
			wr(8'h08, 32'(c[i]), 2'b00);
			#1 chk(32'({mode_code, talk_only, listen_only}), 32'(e[i]));
			rd(8'h14, 32'({e[i][4:2], 4'h0}), 2'b00);
		end
		$display("t_modes done");
	endtask
	task automatic t_primary;
		wr(8'h08, 32'h0000_0031, 2'b00);
		wr(8'h0C, 32'h0000_0005, 2'b00);
		hit(1'b1, 5'h05, 4'h8);
		hit(1'b0, 5'h05, 4'h4);
		hit(1'b1, 5'h06, 4'h0);
		rd(8'h14, 32'h0000_0013, 2'b00);
		rd(8'h14, 32'h0000_0010, 2'b00);
		wr(8'h0C, 32'h0000_0045, 2'b00);
		hit(1'b1, 5'h05, 4'h0);
		hit(1'b0, 5'h05, 4'h4);
		wr(8'h0C, 32'h0000_0025, 2'b00);
		hit(1'b0, 5'h05, 4'h0);
		hit(1'b1, 5'h05, 4'h8);
		wr(8'h08, 32'h0000_0032, 2'b00);
		hit(1'b1, 5'h05, 4'h8);
		wr(8'h08, 32'h0000_0030, 2'b00);
		hit(1'b1, 5'h05, 4'h0);
		wr(8'h08, 32'h0000_00B0, 2'b00);
		hit(1'b1, 5'h05, 4'h0);
		$display("t_primary done");
	endtask
	task automatic t_second;
		wr(8'h08, 32'h0000_0031, 2'b00);
		wr(8'h10, 32'h0000_010A, 2'b00);
		hit(1'b1, 5'h0A, 4'h2);
		hit(1'b0, 5'h0A, 4'h1);
		wr(8'h10, 32'h0000_000A, 2'b00);
		hit(1'b1, 5'h0A, 4'h0);
		$display("t_second done");
	endtask
	// A refused write and an accepted write without byte lane 0 must leave the mode alone
	task automatic t_bus;
		wr(8'h20, 32'h0000_0033, 2'b10);
		rd(8'h20, 32'h0000_0000, 2'b10);
		wstrb <= 4'hE;
		wr(8'h08, 32'h0000_0033, 2'b00);
		wstrb <= 4'hF;
		#1 chk(32'(mode_code), 32'h0000_0001);
		$display("t_bus done");
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		#200_000;
		miscompares++;
		test_done;
	end
	initial begin
		aresetn = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
		wstrb = 4'hF;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_modes;
		t_primary;
		t_second;
		t_bus;
		test_done;
	end
endmodule // tb_top
